// ### hdl/osc_dev.sv
// Purpose: Switch end: serial command port and eight output controls
// Assumes: Link clock idles low while deselected and at select edges
// Notes:   Status and frame toggle are quasi-static across the link;
//          the link side has no reset, so a toggle marks each frame.
//          Status leaves MSB first, the MSB shown before the first link clock rise.
`timescale 1ns/100ps
module osc_dev (
    input  wire logic              clk,           // Core clock
    input  wire logic              rst,           // Sync reset, high
    osc_if.dev                     lnk,           // Serial pins
    input  wire logic [osc_pkg::OSC_W-1:0] open_load, // Off, drain low
    input  wire logic [osc_pkg::OSC_W-1:0] short_det, // On, drain high
    input  wire logic              over_volt,     // Supply overvoltage
    output logic [osc_pkg::OSC_W-1:0]      sw_on      // Switch drive
);
    import osc_pkg::*;

    // Core domain state
    logic             cs_s1_q, cs_s2_q, cs_s3_q;
    logic             rs_s1_q, rs_s2_q;
    logic             sp_s1_q, sp_s2_q;
    logic             frm_tog_q;
    logic [OSC_W-1:0] status_q;
    logic [OSC_W-1:0] status_d;
    logic [OSC_W-1:0] cmd_q;
    logic [OSC_W-1:0] latch_off_q;
    logic [OSC_W-1:0] sw_on_q;
    logic             ov_flag_q;
    logic             cs_fall, cs_rise, take_cmd;
    // Link domain state
    logic [OSC_W-1:0] rx_q;
    logic [3:0]       cnt_q;
    logic             seen_f_q;
    logic             seen_r_q;
    logic [3:0]       idx_q;
    logic             so_bit_q;
    logic             so_d;

    // Crossing plan: the core side snapshots status and toggles
    // frm_tog_q at select fall; the link side compares its own copies
    // of the toggle against it to spot a new frame. Both words are
    // settled long before the first link edge, as the master leaves
    // a lead time after select falls.

    // Select pin synchroniser, third stage only for edge finding
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= lnk.cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // Reset pin synchroniser, starts asserted
    always_ff @(posedge clk) begin
        if (rst) begin
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
        end else begin
            rs_s1_q <= lnk.rst_n_line;
            rs_s2_q <= rs_s1_q;
        end
    end

    // Protect disable pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_s1_q <= 1'b0;
            sp_s2_q <= 1'b0;
        end else begin
            sp_s1_q <= lnk.spd;
            sp_s2_q <= sp_s1_q;
        end
    end

    assign cs_fall = cs_s3_q & ~cs_s2_q;
    assign cs_rise = ~cs_s3_q & cs_s2_q;
    // Only a frame of this selection with eight or more bits counts.
    // Link clock is quiet once select is high, so rx_q is stable here.
    assign take_cmd = cs_rise & rs_s2_q & (seen_f_q == frm_tog_q)
                    & (cnt_q >= OSC_BITS);

    // Drain status: off reads high unless open, on reads low unless
    // the drain is pulled up by a short or a latch-off
    always_comb begin
        for (int i = 0; i < OSC_W; i++) begin
            if (cmd_q[i])
                status_d[i] = ~open_load[i];
            else
                status_d[i] = short_det[i] | latch_off_q[i];
        end
        if (ov_flag_q)
            status_d = OSC_STAT_OV;
    end

    // Status snapshot and frame toggle at select fall
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q  <= OSC_CMD_RST;
            frm_tog_q <= 1'b0;
        end else if (cs_fall) begin
            status_q  <= status_d;
            frm_tog_q <= ~frm_tog_q;
        end
    end

    // Command register; reset pin and overvoltage both clear it
    // Overvoltage outranks a command taken in the same cycle
    always_ff @(posedge clk) begin
        if (rst || !rs_s2_q) begin
            cmd_q <= OSC_CMD_RST;
        end else if (over_volt) begin
            cmd_q <= OSC_CMD_RST;
        end else if (take_cmd) begin
            cmd_q <= rx_q;
        end
    end

    // Overvoltage marker holds until a new command; set wins
    always_ff @(posedge clk) begin
        if (rst || !rs_s2_q)
            ov_flag_q <= 1'b0;
        else if (over_volt)
            ov_flag_q <= 1'b1;
        else if (take_cmd)
            ov_flag_q <= 1'b0;
    end

    // Per-output short latch-off, one copy per output
    for (genvar g = 0; g < OSC_W; g++) begin : g_lat
        always_ff @(posedge clk) begin
            if (rst || !rs_s2_q)
                latch_off_q[g] <= 1'b0;
            else if (short_det[g] && !cmd_q[g] && !sp_s2_q)
                latch_off_q[g] <= 1'b1;
            else if (take_cmd)
                latch_off_q[g] <= 1'b0;
        end
    end

    // Switch drive: on when commanded low and nothing forces it off.
    // With protect disable high a short leaves the output on.
    always_ff @(posedge clk) begin
        if (rst || !rs_s2_q)
            sw_on_q <= '0;
        else if (over_volt)
            sw_on_q <= '0;
        else
            sw_on_q <= ~cmd_q & ~latch_off_q;
    end

    // Port follows its flop directly, no logic behind it
    assign sw_on = sw_on_q;

    // Input shift on the falling link edge. No reset here: the link
    // clock is absent in reset, so a fresh toggle starts each frame.
    // The compare is written so an unknown start selects a new frame.
    always_ff @(negedge lnk.sclk) begin
        if (!lnk.cs_n) begin
            rx_q <= {rx_q[OSC_W-2:0], lnk.si};
            if (seen_f_q == frm_tog_q) begin
                if (cnt_q < OSC_BITS)
                    cnt_q <= cnt_q + 4'h1;
            end else begin
                seen_f_q <= frm_tog_q;
                cnt_q    <= 4'h1;
            end
        end
    end

    // Output shift on the rising link edge. The first rise of a frame
    // repeats the snapshot MSB, so the master's first falling-edge
    // sample is output seven. Rises two to eight walk down to output
    // zero; from the ninth rise on, the serial input re-emerges eight
    // clocks late, which lets devices be chained.
    always_ff @(posedge lnk.sclk) begin
        if (!lnk.cs_n) begin
            if (seen_r_q == frm_tog_q) begin
                if (idx_q < OSC_BITS) begin
                    // idx_q counts the status bits already shown
                    so_bit_q <= status_q[3'(OSC_W - 1 - idx_q)];
                    idx_q    <= idx_q + 4'h1;
                end else begin
                    // Oldest input bit sits at the top of rx_q
                    so_bit_q <= rx_q[OSC_W-1];
                end
            end else begin
                // First rise of this selection
                seen_r_q <= frm_tog_q;
                so_bit_q <= status_q[OSC_W-1];
                idx_q    <= 4'h1;
            end
        end
    end

    // Before the first rising edge the MSB of the snapshot is shown
    always_comb begin
        if (seen_r_q == frm_tog_q)
            so_d = so_bit_q;
        else
            so_d = status_q[OSC_W-1];
    end

    // Driver follows select only; reset pin plays no part
    assign lnk.so    = so_d;
    assign lnk.so_oe = ~lnk.cs_n;
endmodule

// ### hdl/osc_pkg.sv
// Purpose: Shared constants for the octal switch serial control link
// Assumes: Core clock clk at 20 MHz; link clock made by the host end
// Notes:   Both ends and the bench import this package
package osc_pkg;
    localparam int          OSC_W        = 8;
    localparam logic [7:0]  OSC_CMD_RST  = 8'hFF;   // All outputs off
    localparam logic [7:0]  OSC_STAT_OV  = 8'hFF;
    localparam logic [3:0]  OSC_BITS     = 4'h8;
    // Timing in the core clock domain
    localparam int          OSC_CLK_NS   = 50;
    localparam int          OSC_RST_NS   = 250;
    localparam logic [3:0]  OSC_RST_CYC  =
        4'((OSC_RST_NS + OSC_CLK_NS - 1) / OSC_CLK_NS);
    localparam logic [3:0]  OSC_HALF_CYC = 4'h4;    // Half link period
    localparam logic [3:0]  OSC_SI_CHG   = 4'h2;    // SI change point
    localparam logic [3:0]  OSC_LEAD_CYC = 4'h8;    // Select to clock
    localparam logic [3:0]  OSC_GAP_CYC  = 4'h8;    // Idle after frame
    typedef enum logic [2:0] {
        OSC_IDLE, OSC_LEAD, OSC_HI, OSC_LO, OSC_TRAIL, OSC_GAP
    } osc_hst_t;
endpackage

// ### hdl/osc_if.sv
// Purpose: Pin bundle between master end and switch end
// Assumes: Serial output line floats high when not driven
// Notes:   Reset line pulled low when the master does not drive it
`timescale 1ns/100ps
interface osc_if;
    logic cs_n;       // Chip select, active low
    logic sclk;       // Link clock from the master
    logic si;         // Serial data to the switch end
    logic so;         // Serial data from the switch end
    logic so_oe;      // Switch end drives so
    logic so_line;    // Resolved serial output level
    logic rst_n_o;    // Master reset drive value
    logic rst_n_oe;   // Master drives reset
    logic rst_n_line; // Resolved reset level
    logic spd;        // Short protect disable level

    // Undriven output idles high
    assign so_line    = so_oe ? so : 1'b1;
    // Weak pull-down: undriven reset is asserted
    assign rst_n_line = rst_n_oe ? rst_n_o : 1'b0;

    modport dev  (input cs_n, sclk, si, rst_n_line, spd,
                  output so, so_oe);
    modport host (output cs_n, sclk, si, rst_n_o, rst_n_oe, spd,
                  input so_line);
endinterface

// ### hdl/osc_host.sv
// Purpose: Master end: runs one 8-bit exchange per start request
// Assumes: Link clock derived from clk; switch end follows the pins
// Notes:   Returned status belongs to the previous command
`timescale 1ns/100ps
module osc_host (
    input  wire logic              clk,       // Core clock
    input  wire logic              rst,       // Sync reset, high
    osc_if.host                    lnk,       // Serial pins
    input  wire logic              start,     // Begin exchange, pulse
    input  wire logic [osc_pkg::OSC_W-1:0] cmd, // Command word
    input  wire logic              rst_req,   // Hold switch reset
    input  wire logic              spd_set,   // Protect disable level
    output logic                   busy,      // Exchange running
    output logic                   done,      // Exchange ended, pulse
    output logic [osc_pkg::OSC_W-1:0] status  // Returned status
);
    import osc_pkg::*;

    osc_hst_t         st_q;
    logic [3:0]       tm_q;
    logic [2:0]       bit_q;
    logic [OSC_W-1:0] tx_q, rx_q, stat_q;
    logic             cs_n_q, sclk_q, si_q;
    logic             busy_q, done_q;
    logic             so_s1_q, so_s2_q;
    logic [3:0]       rc_q;
    logic             rst_n_q, spd_q;

    // Serial output is from another clock, so two flops first
    always_ff @(posedge clk) begin
        if (rst) begin
            so_s1_q <= 1'b1;
            so_s2_q <= 1'b1;
        end else begin
            so_s1_q <= lnk.so_line;
            so_s2_q <= so_s1_q;
        end
    end

    // Frame sequencer; clock is low at both select edges
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= OSC_IDLE;
            tm_q   <= 4'h0;
            bit_q  <= 3'h0;
            tx_q   <= OSC_CMD_RST;
            rx_q   <= OSC_CMD_RST;
            stat_q <= OSC_CMD_RST;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            si_q   <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                OSC_IDLE: begin
                    if (start) begin
                        tx_q   <= cmd;
                        si_q   <= cmd[OSC_W-1];
                        cs_n_q <= 1'b0;
                        busy_q <= 1'b1;
                        bit_q  <= 3'h0;
                        tm_q   <= OSC_LEAD_CYC - 4'h1;
                        st_q   <= OSC_LEAD;
                    end
                end
                OSC_LEAD: begin
                    if (tm_q == 4'h0) begin
                        sclk_q <= 1'b1;
                        tm_q   <= OSC_HALF_CYC - 4'h1;
                        st_q   <= OSC_HI;
                    end else
                        tm_q <= tm_q - 4'h1;
                end
                OSC_HI: begin
                    if (tm_q == 4'h0) begin
                        sclk_q <= 1'b0;
                        tm_q   <= OSC_HALF_CYC - 4'h1;
                        st_q   <= OSC_LO;
                    end else
                        tm_q <= tm_q - 4'h1;
                end
                OSC_LO: begin
                    // SI moves mid-low, away from both clock edges
                    if (tm_q == OSC_SI_CHG) begin
                        tx_q <= {tx_q[OSC_W-2:0], 1'b1};
                        si_q <= tx_q[OSC_W-2];
                    end
                    if (tm_q == 4'h0) begin
                        rx_q <= {rx_q[OSC_W-2:0], so_s2_q};
                        if (bit_q == 3'h7) begin
                            tm_q <= OSC_LEAD_CYC - 4'h1;
                            st_q <= OSC_TRAIL;
                        end else begin
                            bit_q  <= bit_q + 3'h1;
                            sclk_q <= 1'b1;
                            tm_q   <= OSC_HALF_CYC - 4'h1;
                            st_q   <= OSC_HI;
                        end
                    end else
                        tm_q <= tm_q - 4'h1;
                end
                OSC_TRAIL: begin
                    if (tm_q == 4'h0) begin
                        cs_n_q <= 1'b1;
                        stat_q <= rx_q;
                        tm_q   <= OSC_GAP_CYC - 4'h1;
                        st_q   <= OSC_GAP;
                    end else
                        tm_q <= tm_q - 4'h1;
                end
                OSC_GAP: begin
                    // Lets the switch end see select high first
                    if (tm_q == 4'h0) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q   <= OSC_IDLE;
                    end else
                        tm_q <= tm_q - 4'h1;
                end
                default: st_q <= OSC_IDLE;
            endcase
        end
    end

    // Reset drive stretched to the least hold time
    always_ff @(posedge clk) begin
        if (rst) begin
            rc_q    <= OSC_RST_CYC;
            rst_n_q <= 1'b0;
        end else if (rst_req) begin
            rc_q    <= OSC_RST_CYC;
            rst_n_q <= 1'b0;
        end else if (rc_q != 4'h0) begin
            rc_q    <= rc_q - 4'h1;
            rst_n_q <= 1'b0;
        end else
            rst_n_q <= 1'b1;
    end

    // Protect disable is a plain level from the user
    always_ff @(posedge clk) begin
        if (rst)
            spd_q <= 1'b0;
        else
            spd_q <= spd_set;
    end

    assign lnk.cs_n     = cs_n_q;
    assign lnk.sclk     = sclk_q;
    assign lnk.si       = si_q;
    assign lnk.rst_n_o  = rst_n_q;
    assign lnk.rst_n_oe = 1'b1;
    assign lnk.spd      = spd_q;
    assign busy         = busy_q;
    assign done         = done_q;
    assign status       = stat_q;
endmodule

// ### sim/osc_asserts.sv
// Purpose: Wire-level assertions for the octal switch serial link
// Assumes: Host makes sclk from clk, so clk sees every link edge
// Notes:   Helper counters run on clk; bench instantiates beside lnk
`timescale 1ns/100ps
module osc_asserts (
    input  wire logic clk,        // Core clock
    input  wire logic rst,        // Sync reset, high
    input  wire logic cs_n,       // Chip select, active low
    input  wire logic sclk,       // Link clock
    input  wire logic si,         // Data to switch end
    input  wire logic so,         // Data from switch end
    input  wire logic so_oe,      // Switch end drives so
    input  wire logic so_line,    // Resolved so level
    input  wire logic rst_n_line  // Resolved reset pin
);
    logic       sclk_q;
    logic [3:0] fall_q;
    logic [3:0] low_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Previous link clock level for edge finding
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
    end
    // Falls per selection; saturates so a runaway frame still fails
    always_ff @(posedge clk) begin
        if (cs_n) begin
            fall_q <= 4'h0;
        end else if (sclk_q && !sclk && fall_q != 4'hF) begin
            fall_q <= fall_q + 4'h1;
        end
    end
    // Reset pin low time; core reset restarts the count at one
    always_ff @(posedge clk) begin
        if (rst_n_line) begin
            low_q <= 4'h0;
        end else if (rst) begin
            low_q <= 4'h1;
        end else if (low_q != 4'hF) begin
            low_q <= low_q + 4'h1;
        end
    end

    property p_float;
        cs_n |-> !so_oe && so_line;
    endproperty
    a_float: assert property (p_float)
        else $error("so driven while deselected");
    property p_drive;
        !cs_n |-> so_oe;
    endproperty
    a_drive: assert property (p_drive)
        else $error("so not driven while selected");
    property p_edge_low;
        $changed(cs_n) |-> !sclk && !$past(sclk);
    endproperty
    a_edge_low: assert property (p_edge_low)
        else $error("select moved with link clock high");
    property p_idle_low;
        cs_n |-> !sclk;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("link clock high while deselected");
    property p_si_fall;
        $fell(sclk) |-> $stable(si) ##1 $stable(si);
    endproperty
    a_si_fall: assert property (p_si_fall)
        else $error("si moved at sampling fall");
    property p_so_hold;
        (!cs_n && $past(!cs_n, 7) && !$rose(sclk)) |-> $stable(so);
    endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("so changed away from link clock rise");
    property p_si_rise;
        $rose(sclk) |-> $stable(si);
    endproperty
    a_si_rise: assert property (p_si_rise)
        else $error("si moved at link clock rise");
    property p_eight;
        $rose(cs_n) |-> fall_q == 4'h8;
    endproperty
    a_eight: assert property (p_eight)
        else $error("frame did not hold eight clock falls");
    property p_rst_len;
        $rose(rst_n_line) |-> low_q >= 4'h5;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset pin released too early");
endmodule

// ### sim/test_octal_switch_serial_control.sv
// Purpose: Self-checking bench, host end facing switch end
// Assumes: 20 MHz core clock; host derives the link clock
// Notes:   Status seen belongs to the previous command word
`timescale 1ns/100ps
module test_octal_switch_serial_control;
    import osc_pkg::*;
    logic       clk;
    logic       rst;
    logic       start;
    logic [7:0] cmd;
    logic       rst_req;
    logic       spd_set;
    logic [7:0] open_load;
    logic [7:0] short_det;
    logic       over_volt;
    logic       busy;
    logic       done;
    logic [7:0] status;
    logic [7:0] sw_on;
    logic [7:0] rx_si;
    logic [7:0] rx_so;
    logic       sclk_p;
    int         err_total;
    int         samples_checked;

    osc_if lnk ();
    osc_host u_osc_host (.clk(clk), .rst(rst), .lnk(lnk), .start(start),
        .cmd(cmd), .rst_req(rst_req), .spd_set(spd_set), .busy(busy),
        .done(done), .status(status));
    osc_dev u_osc_dev (.clk(clk), .rst(rst), .lnk(lnk),
        .open_load(open_load), .short_det(short_det),
        .over_volt(over_volt), .sw_on(sw_on));
    osc_asserts chk (.clk(clk), .rst(rst), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe),
        .so_line(lnk.so_line), .rst_n_line(lnk.rst_n_line));

    // Core clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Sample both data wires at each link clock fall
    always @(posedge clk) begin
        if (!lnk.cs_n && sclk_p && !lnk.sclk) begin
            rx_si = {rx_si[6:0], lnk.si};
            rx_so = {rx_so[6:0], lnk.so_line};
        end
        sclk_p = lnk.sclk;
    end

    task automatic summarize;
        $display("Mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One exchange; bounded wait on done, then judge word and wires
    task automatic xfer(input logic [7:0] c, input logic [7:0] exp_st);
        int n;
        n = 0;
        start <= 1'b1;
        cmd   <= c;
        @(posedge clk);
        start <= 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n == 1)
                chk8("busy", 8'h01, {7'h00, busy});
            if (n > 200) begin
                err_total++;
                summarize();
            end
        end
        chk8("busy", 8'h00, {7'h00, busy});
        chk8("status", exp_st, status);
        chk8("si wire", c, rx_si);
        chk8("so wire", exp_st, rx_so);
    endtask
    // Switch drive settles 3..5 cycles after select rises
    task automatic sw_chk(input logic [7:0] exp);
        repeat (8) @(posedge clk);
        chk8("sw_on", exp, sw_on);
    endtask

    task automatic scn_reset;
        chk8("sw_on", 8'h00, sw_on);
        chk8("status", 8'hFF, status);
        repeat (12) @(posedge clk);
    endtask
    task automatic scn_cmd;
        xfer(8'hA5, 8'hFF);
        sw_chk(8'h5A);
        xfer(8'h3C, 8'hA5);
        sw_chk(8'hC3);
    endtask
    // Off output with drain low reads zero
    task automatic scn_open;
        open_load <= 8'h04;
        xfer(8'h3C, 8'h38);
        open_load <= 8'h00;
    endtask
    // Short on output 0: kept on, then latched off, then cleared
    task automatic scn_short;
        // Protect disable must pass its synchroniser before the short
        spd_set   <= 1'b1;
        repeat (4) @(posedge clk);
        short_det <= 8'h01;
        repeat (10) @(posedge clk);
        chk8("sw_on", 8'hC3, sw_on);
        spd_set <= 1'b0;
        repeat (10) @(posedge clk);
        chk8("sw_on", 8'hC2, sw_on);
        short_det <= 8'h00;
        xfer(8'h3C, 8'h3D);
        sw_chk(8'hC3);
    endtask
    task automatic scn_ov;
        over_volt <= 1'b1;
        repeat (4) @(posedge clk);
        chk8("sw_on", 8'h00, sw_on);
        over_volt <= 1'b0;
        repeat (4) @(posedge clk);
        // Open load on an off output would read zero without the marker
        open_load <= 8'h04;
        xfer(8'h3C, 8'hFF);
        open_load <= 8'h00;
        sw_chk(8'hC3);
    endtask
    // Mid-run reset pin, then three exchanges, the last two back to back
    task automatic scn_rst_b2b;
        rst_req <= 1'b1;
        repeat (8) @(posedge clk);
        chk8("sw_on", 8'h00, sw_on);
        rst_req <= 1'b0;
        repeat (14) @(posedge clk);
        xfer(8'h00, 8'hFF);
        sw_chk(8'hFF);
        xfer(8'h81, 8'h00);
        xfer(8'h7E, 8'h81);
        sw_chk(8'h81);
    endtask

    initial begin
        err_total = 0;
        samples_checked = 0;
        rst = 1'b1;
        start = 1'b0;
        cmd = 8'h00;
        rst_req = 1'b0;
        spd_set = 1'b0;
        open_load = 8'h00;
        short_det = 8'h00;
        over_volt = 1'b0;
        sclk_p = 1'b0;
        rx_si = 8'h00;
        rx_so = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        scn_reset();
        scn_cmd();
        scn_open();
        scn_short();
        scn_ov();
        scn_rst_b2b();
        summarize();
    end
endmodule
